//--- core/qpm_memory_map.sv
// Overview of operation
// RULE1 - sixteen nine-bit volatile locations addressed by four address bits
// RULE2 - only four wipers and two terminal-control registers exist; rest reserved
// RULE3 - reset loads wipers with mid-scale: 80h eight-bit, 40h seven-bit
// RULE4 - wipers at 0,1,6,7 take all commands; control at 4,A read/write only
// RULE5 - reserved address or inc/dec on control register raises the error condition
// RULE6 - error clears when high-voltage pin goes to normal high then active again
// RULE7 - each control register holds eight bits, four per network
// RULE8 - written control value reaches network terminals only after command completes
// RULE9 - reset loads both control registers with 1FFh, all connected
// RULE10 - host must detect reset and rewrite control registers itself
// RULE11 - control bit 8 is read-only and always reads one
// RULE12 - bits 7 and 3 cleared force networks 1 and 0 into shutdown
// RULE13 - bits 6 and 2 connect terminal A of networks 1 and 0
// RULE14 - bits 5 and 1 connect the wiper of networks 1 and 0
// RULE15 - bits 4 and 0 connect terminal B of networks 1 and 0
// RULE16 - second control register has the same layout for networks 3 and 2
// RULE17 - control bits never alter wiper register contents
// RULE18 - reset pin low holds defaults and disables command interface
// RULE19 - disallowed command changes nothing; commands ignored until error exit
module qpm_memory_map
    import qpm_pkg::*;
#(
    parameter bit EIGHT_BIT = 1'b1
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // pins from outside the clock domain
    input  wire logic        reset_pin_n,
    input  wire logic        hvc_high_level,
    // command port from the serial engine
    input  wire logic        req_valid,
    input  wire qpm_req_type req,
    input  wire logic        req_done,
    // answers
    output logic             rsp_valid,
    output logic [8:0]       rsp_data,
    output logic             error_q,
    output logic             serial_enable,
    // network drive
    output qpm_net_type [3:0] net_ctrl
);
    localparam logic [8:0] WIPER_RST = EIGHT_BIT ? QPM_WIPER_MID_8BIT : QPM_WIPER_MID_7BIT;

    logic [1:0]  rst_pin_sync_q;
    logic [1:0]  hvc_sync_q;
    logic        hvc_prev_q;
    logic        hvc_seen_high_q;
    logic        hold_rst;
    logic [8:0]  mem_q [16];
    logic [7:0]  tctl_lo_pend_q;
    logic [7:0]  tctl_hi_pend_q;
    logic        pend_lo_q;
    logic        pend_hi_q;
    logic        legal;
    logic        is_wiper;
    logic        is_tctl;
    logic        err_event;
    logic        err_exit;

    function automatic logic addr_is_wiper(input logic [3:0] a);
        return a == QPM_ADDR_WIPER0 || a == QPM_ADDR_WIPER1
            || a == QPM_ADDR_WIPER2 || a == QPM_ADDR_WIPER3;
    endfunction

    function automatic logic addr_is_tctl(input logic [3:0] a);
        return a == QPM_ADDR_TCTL_LO || a == QPM_ADDR_TCTL_HI;
    endfunction

    function automatic logic [8:0] reset_value(input logic [3:0] a);
        if (addr_is_wiper(a)) begin
            return WIPER_RST;
        end
        return addr_is_tctl(a) ? QPM_TCTL_RESET : 9'h000;
    endfunction

    // both pins are asynchronous to clk
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_pin_sync_q <= 2'b00;
            hvc_sync_q     <= 2'b00;
        end else begin
            rst_pin_sync_q <= {rst_pin_sync_q[0], reset_pin_n};
            hvc_sync_q     <= {hvc_sync_q[0], hvc_high_level};
        end
    end

    assign hold_rst = srst || !rst_pin_sync_q[1]; // RULE18

    always_comb begin
        is_wiper = addr_is_wiper(req.addr);
        is_tctl  = addr_is_tctl(req.addr);
        legal    = is_wiper
            || (is_tctl && (req.cmd == QPM_CMD_READ || req.cmd == QPM_CMD_WRITE)); // RULE4
    end

    assign err_event = req_valid && !error_q && !legal; // RULE5
    // exit: pin reaches normal high, then falls back to an active level
    assign err_exit  = hvc_seen_high_q && hvc_prev_q && !hvc_sync_q[1]; // RULE6

    // previous level; resets to the active level so no false fall follows reset
    always_ff @(posedge clk) begin
        if (hold_rst) begin
            hvc_prev_q <= 1'b0;
        end else begin
            hvc_prev_q <= hvc_sync_q[1];
        end
    end

    // a high level only counts once an error is present
    always_ff @(posedge clk) begin
        if (hold_rst) begin
            hvc_seen_high_q <= 1'b0;
        end else if (!error_q || err_exit) begin
            hvc_seen_high_q <= 1'b0;
        end else if (hvc_sync_q[1]) begin
            hvc_seen_high_q <= 1'b1; // RULE6
        end
    end

    always_ff @(posedge clk) begin
        if (hold_rst) begin
            error_q <= 1'b0;
        end else if (err_event) begin
            error_q <= 1'b1; // RULE5
        end else if (err_exit) begin
            error_q <= 1'b0; // RULE6
        end
    end

    // memory array; reserved words stay zero and are never written
    always_ff @(posedge clk) begin
        if (hold_rst) begin
            for (int i = 0; i < 16; i++) begin
                mem_q[i] <= reset_value(4'(i)); // RULE1 RULE3 RULE9
            end
        end else if (req_valid && !error_q && legal) begin // RULE19
            unique case (req.cmd)
                QPM_CMD_WRITE: begin
                    if (is_tctl) begin
                        mem_q[req.addr] <= {1'b1, req.data[7:0]}; // RULE11 RULE7
                    end else begin
                        mem_q[req.addr] <= req.data; // RULE2
                    end
                end
                // inc/dec limits are left to the command engine
                QPM_CMD_INCR: mem_q[req.addr] <= mem_q[req.addr] + 9'h001;
                QPM_CMD_DECR: mem_q[req.addr] <= mem_q[req.addr] - 9'h001;
                default: ;
            endcase
        end
    end

    // read answer lasts one cycle; nothing is answered while in error
    always_ff @(posedge clk) begin
        if (hold_rst) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= req_valid && !error_q && legal && req.cmd == QPM_CMD_READ; // RULE4
        end
    end

    // reserved locations never put stale data on the answer
    always_ff @(posedge clk) begin
        if (hold_rst) begin
            rsp_data <= 9'h000;
        end else begin
            rsp_data <= (req_valid && legal) ? mem_q[req.addr] : 9'h000;
        end
    end

    // control writes wait for the end of the serial command before reaching the network
    always_ff @(posedge clk) begin
        if (hold_rst) begin
            pend_lo_q      <= 1'b0;
            tctl_lo_pend_q <= QPM_TCTL_RESET[7:0];
        end else if (req_done) begin
            pend_lo_q <= 1'b0;
        end else if (req_valid && !error_q && req.cmd == QPM_CMD_WRITE
                     && req.addr == QPM_ADDR_TCTL_LO) begin
            pend_lo_q      <= 1'b1; // RULE8
            tctl_lo_pend_q <= req.data[7:0];
        end
    end

    // a second write before completion replaces the pending value
    always_ff @(posedge clk) begin
        if (hold_rst) begin
            pend_hi_q      <= 1'b0;
            tctl_hi_pend_q <= QPM_TCTL_RESET[7:0];
        end else if (req_done) begin
            pend_hi_q <= 1'b0;
        end else if (req_valid && !error_q && req.cmd == QPM_CMD_WRITE
                     && req.addr == QPM_ADDR_TCTL_HI) begin
            pend_hi_q      <= 1'b1; // RULE8
            tctl_hi_pend_q <= req.data[7:0];
        end
    end

    // network drive only touches control copies, never wipers
    always_ff @(posedge clk) begin
        if (hold_rst) begin
            net_ctrl <= {4{4'hF}}; // RULE9
        end else if (req_done) begin // RULE8 RULE17
            if (pend_lo_q) begin
                net_ctrl[1] <= tctl_lo_pend_q[7:4]; // RULE12 RULE13 RULE14 RULE15
                net_ctrl[0] <= tctl_lo_pend_q[3:0];
            end
            if (pend_hi_q) begin
                net_ctrl[3] <= tctl_hi_pend_q[7:4]; // RULE16
                net_ctrl[2] <= tctl_hi_pend_q[3:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (hold_rst) begin
            serial_enable <= 1'b0; // RULE18
        end else begin
            serial_enable <= 1'b1;
        end
    end

    // memory contents and read answers
    tctl_bit8_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE11
        mem_q[QPM_ADDR_TCTL_LO][QPM_BIT_ONE] && mem_q[QPM_ADDR_TCTL_HI][QPM_BIT_ONE])
        else $error("control bit 8 not one");

    reserved_zero_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE2
        mem_q[2] == 9'h000 && mem_q[3] == 9'h000 && mem_q[5] == 9'h000
            && mem_q[8] == 9'h000 && mem_q[9] == 9'h000 && mem_q[11] == 9'h000
            && mem_q[12] == 9'h000 && mem_q[13] == 9'h000 && mem_q[14] == 9'h000
            && mem_q[15] == 9'h000)
        else $error("reserved location written");

    tctl_write_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE7 RULE11
        req_valid && !error_q && req.cmd == QPM_CMD_WRITE && req.addr == QPM_ADDR_TCTL_HI
        |=> mem_q[QPM_ADDR_TCTL_HI] == {1'b1, $past(req.data[7:0])})
        else $error("control write stored wrongly");

    wiper_write_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE4
        req_valid && !error_q && req.cmd == QPM_CMD_WRITE && req.addr == QPM_ADDR_WIPER1
        |=> mem_q[1] == $past(req.data))
        else $error("wiper write lost");

    incr_step_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE4
        req_valid && !error_q && is_wiper && req.cmd == QPM_CMD_INCR
        |=> mem_q[$past(req.addr)] == $past(mem_q[req.addr]) + 9'h001)
        else $error("wiper increment wrong");

    decr_step_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE4
        req_valid && !error_q && is_wiper && req.cmd == QPM_CMD_DECR
        |=> mem_q[$past(req.addr)] == $past(mem_q[req.addr]) - 9'h001)
        else $error("wiper decrement wrong");

    wiper_keep_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE17
        (req_valid && is_tctl) || (req_done && !req_valid)
        |=> mem_q[0] == $past(mem_q[0]) && mem_q[1] == $past(mem_q[1])
            && mem_q[6] == $past(mem_q[6]) && mem_q[7] == $past(mem_q[7]))
        else $error("wiper changed by control traffic");

    read_answer_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE4
        req_valid && !error_q && legal && req.cmd == QPM_CMD_READ
        |=> rsp_valid && rsp_data == $past(mem_q[req.addr]))
        else $error("read answer wrong");

    rsp_zero_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE2
        req_valid && !legal |=> rsp_data == 9'h000 && !rsp_valid)
        else $error("reserved read answered");

    // error condition
    illegal_err_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE5
        err_event |=> error_q)
        else $error("illegal command did not raise error");

    err_hold_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE6
        error_q && !err_exit |=> error_q)
        else $error("error dropped without exit");

    exit_needs_high_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE6
        error_q && !hvc_seen_high_q |=> error_q)
        else $error("error left without normal high level");

    exit_clear_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE6
        error_q && err_exit |=> !error_q)
        else $error("error kept after exit sequence");

    no_change_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE19
        req_valid && (error_q || !legal)
        |=> mem_q[0] == $past(mem_q[0]) && mem_q[1] == $past(mem_q[1])
            && mem_q[4] == $past(mem_q[4]) && mem_q[6] == $past(mem_q[6])
            && mem_q[7] == $past(mem_q[7]) && mem_q[10] == $past(mem_q[10]))
        else $error("memory changed on ignored command");

    err_silent_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE19
        error_q |=> !rsp_valid)
        else $error("read answered while in error");

    err_no_pend_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE19
        req_valid && error_q && !req_done |=> $stable(pend_lo_q) && $stable(pend_hi_q))
        else $error("control write taken while in error");

    // network drive
    net_wait_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE8
        !req_done |=> net_ctrl == $past(net_ctrl))
        else $error("network changed before command end");

    pend_set_a: assert property (@(posedge clk) disable iff (hold_rst) // RULE8
        req_valid && !error_q && !req_done && req.cmd == QPM_CMD_WRITE
            && req.addr == QPM_ADDR_TCTL_LO
        |=> pend_lo_q && tctl_lo_pend_q == $past(req.data[7:0]))
        else $error("control write not held pending");

    net_apply_lo_a: assert property (@(posedge clk) // RULE12 RULE13 RULE14 RULE15
        disable iff (hold_rst)
        req_done && pend_lo_q |=> net_ctrl[1:0] == $past(tctl_lo_pend_q))
        else $error("low pair network drive wrong");

    net_apply_hi_a: assert property (@(posedge clk) // RULE16
        disable iff (hold_rst)
        req_done && pend_hi_q |=> net_ctrl[3:2] == $past(tctl_hi_pend_q))
        else $error("high pair network drive wrong");

    // reset
    rst_default_a: assert property (@(posedge clk) // RULE3 RULE9 RULE18
        $past(hold_rst) |-> mem_q[0] == WIPER_RST && mem_q[1] == WIPER_RST
            && mem_q[6] == WIPER_RST && mem_q[7] == WIPER_RST
            && mem_q[4] == QPM_TCTL_RESET && mem_q[10] == QPM_TCTL_RESET
            && net_ctrl == {4{4'hF}} && !serial_enable && !error_q)
        else $error("reset defaults wrong");

    serial_off_a: assert property (@(posedge clk) // RULE18
        hold_rst |=> !serial_enable && !rsp_valid)
        else $error("interface active during reset");

    // main scenarios
    incr_c: cover property (@(posedge clk) req_valid && legal && req.cmd == QPM_CMD_INCR);
    err_c: cover property (@(posedge clk) err_event ##[1:200] err_exit);
    tctl_c: cover property (@(posedge clk) pend_lo_q && req_done);
    read_c: cover property (@(posedge clk) rsp_valid);
    pin_c: cover property (@(posedge clk) $fell(rst_pin_sync_q[1]) ##[1:20] !hold_rst);
endmodule

//--- core/qpm_pkg.sv
package qpm_pkg;
    // location addresses
    localparam logic [3:0] QPM_ADDR_WIPER0 = 4'h0;
    localparam logic [3:0] QPM_ADDR_WIPER1 = 4'h1;
    localparam logic [3:0] QPM_ADDR_TCTL_LO = 4'h4;
    localparam logic [3:0] QPM_ADDR_WIPER2 = 4'h6;
    localparam logic [3:0] QPM_ADDR_WIPER3 = 4'h7;
    localparam logic [3:0] QPM_ADDR_TCTL_HI = 4'hA;
    // reset values
    localparam logic [8:0] QPM_WIPER_MID_8BIT = 9'h080;
    localparam logic [8:0] QPM_WIPER_MID_7BIT = 9'h040;
    localparam logic [8:0] QPM_TCTL_RESET = 9'h1FF;
    // field positions within a terminal-control nibble, plus the bit-8 position and the word width
    localparam int QPM_BIT_TERM_B = 0;
    localparam int QPM_BIT_WIPER = 1;
    localparam int QPM_BIT_TERM_A = 2;
    localparam int QPM_BIT_SHDN_N = 3;
    localparam int QPM_BIT_ONE = 8;
    localparam int QPM_WIDTH = 9;

    typedef enum logic [1:0] {
        QPM_CMD_WRITE,
        QPM_CMD_INCR,
        QPM_CMD_DECR,
        QPM_CMD_READ
    } qpm_cmd_type;

    typedef struct packed {
        qpm_cmd_type cmd;
        logic [3:0]  addr;
        logic [8:0]  data;
    } qpm_req_type;

    // per network: shutdown_n, term a, wiper, term b
    typedef struct packed {
        logic shutdown_n;
        logic term_a_connect;
        logic wiper_connect;
        logic term_b_connect;
    } qpm_net_type;
endpackage

//--- dv/qpm_host.sv
// host side of the command port: one serial command per call
module qpm_host
    import qpm_pkg::*;
(
    // clock
    input  wire logic   clk,
    // command port
    output logic        req_valid,
    output qpm_req_type req,
    output logic        req_done,
    // high-voltage pin level
    output logic        hvc_high_level
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req_valid      = 1'b0;
        req            = '0;
        req_done       = 1'b0;
        hvc_high_level = 1'b0;
    end

    task automatic send(input qpm_cmd_type c, input logic [3:0] a, input logic [8:0] d);
        @(posedge clk);
        req_valid <= 1'b1;
        req       <= '{cmd: c, addr: a, data: d};
        @(posedge clk);
        req_valid <= 1'b0;
        // released fields never keep the old command
        req       <= qpm_req_type'(~req);
    endtask

    // stop condition seen: the command is complete
    task automatic complete();
        @(posedge clk);
        req_done <= 1'b1;
        @(posedge clk);
        req_done <= 1'b0;
    endtask

    // normal high, then back to the active level
    task automatic leave_error();
        @(posedge clk);
        hvc_high_level <= 1'b1;
        repeat (4) @(posedge clk);
        hvc_high_level <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
endmodule

//--- dv/tb.sv
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb
    import qpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk;
    logic              srst;
    logic              reset_pin_n;
    logic              req_valid;
    qpm_req_type       req;
    logic              req_done;
    logic              hvc_high_level;
    logic              rsp_valid;
    logic [8:0]        rsp_data;
    logic              error_q;
    logic              serial_enable;
    qpm_net_type [3:0] net_ctrl;
    int                errors = 0;
    int                checks = 0;

    qpm_host host (.clk(clk), .req_valid(req_valid), .req(req), .req_done(req_done),
        .hvc_high_level(hvc_high_level));
    qpm_memory_map #(.EIGHT_BIT(1'b1)) uut (.clk(clk), .srst(srst), .reset_pin_n(reset_pin_n),
        .hvc_high_level(hvc_high_level), .req_valid(req_valid), .req(req),
        .req_done(req_done), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .error_q(error_q), .serial_enable(serial_enable), .net_ctrl(net_ctrl));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic rd(input logic [3:0] a, input logic [8:0] e);
        host.send(QPM_CMD_READ, a, 9'h000);
        #1;
        `CHK(rsp_valid, 1'b1)
        `CHK(rsp_data, e)
    endtask

    task automatic t_defaults();
        `CHK(serial_enable, 1'b1)
        `CHK(net_ctrl, 16'hFFFF)
        rd(QPM_ADDR_WIPER0, QPM_WIPER_MID_8BIT);
        rd(QPM_ADDR_WIPER1, QPM_WIPER_MID_8BIT);
        rd(QPM_ADDR_WIPER2, QPM_WIPER_MID_8BIT);
        rd(QPM_ADDR_WIPER3, QPM_WIPER_MID_8BIT);
        rd(QPM_ADDR_TCTL_LO, QPM_TCTL_RESET);
        rd(QPM_ADDR_TCTL_HI, QPM_TCTL_RESET);
        $display("test defaults done");
    endtask

    task automatic t_wiper();
        host.send(QPM_CMD_WRITE, QPM_ADDR_WIPER2, 9'h1A5);
        host.send(QPM_CMD_INCR, QPM_ADDR_WIPER2, 9'h000);
        rd(QPM_ADDR_WIPER2, 9'h1A6);
        host.send(QPM_CMD_DECR, QPM_ADDR_WIPER3, 9'h000);
        rd(QPM_ADDR_WIPER3, 9'h07F);
        `CHK(error_q, 1'b0)
        $display("test wiper done");
    endtask

    task automatic t_tctl();
        host.send(QPM_CMD_WRITE, QPM_ADDR_TCTL_LO, 9'h0A5);
        rd(QPM_ADDR_TCTL_LO, 9'h1A5);
        `CHK(net_ctrl[1:0], 8'hFF)
        host.complete();
        #1;
        `CHK(net_ctrl[1:0], 8'hA5)
        host.send(QPM_CMD_WRITE, QPM_ADDR_TCTL_HI, 9'h13C);
        host.complete();
        #1;
        `CHK(net_ctrl[3:2], 8'h3C)
        rd(QPM_ADDR_WIPER2, 9'h1A6);
        $display("test terminal control done");
    endtask

    task automatic t_error();
        qpm_cmd_type c;
        logic [3:0]  a;
        for (int i = 0; i < 18; i++) begin
            c = qpm_cmd_type'(i % 4);
            a = 4'(i);
            if (i == 16) begin
                c = QPM_CMD_INCR;
                a = QPM_ADDR_TCTL_LO;
            end
            if (i == 17) begin
                c = QPM_CMD_DECR;
                a = QPM_ADDR_TCTL_HI;
            end
            if (i < 16 && a inside {0, 1, 4, 6, 7, 10}) continue;
            host.send(c, a, 9'h000);
            #1;
            `CHK(error_q, 1'b1)
            `CHK(rsp_valid, 1'b0)
            `CHK(rsp_data, 9'h000)
            // must be ignored while in error
            host.send(QPM_CMD_WRITE, QPM_ADDR_WIPER0, 9'h000);
            host.leave_error();
            #1;
            `CHK(error_q, 1'b0)
        end
        rd(QPM_ADDR_WIPER0, QPM_WIPER_MID_8BIT);
        rd(QPM_ADDR_TCTL_LO, 9'h1A5);
        $display("test error done");
    endtask

    task automatic t_pin();
        host.send(QPM_CMD_WRITE, QPM_ADDR_WIPER1, 9'h033);
        reset_pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        `CHK(serial_enable, 1'b0)
        `CHK(net_ctrl, 16'hFFFF)
        @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd(QPM_ADDR_WIPER1, QPM_WIPER_MID_8BIT);
        host.send(QPM_CMD_WRITE, QPM_ADDR_TCTL_LO, 9'h0A5);
        host.complete();
        #1;
        `CHK(net_ctrl, 16'hFFA5)
        $display("test reset pin done");
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end

    initial begin
        srst        = 1'b1;
        reset_pin_n = 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        // synchronisers need a few edges before the first command
        repeat (6) @(posedge clk);
        #1;
        t_defaults();
        t_wiper();
        t_tctl();
        t_error();
        t_pin();
        give_verdict();
    end
endmodule
